// ---- shared/aio_pkg.sv ----
package aio_pkg;

  // data and channel geometry
  localparam int unsigned IN_CH     = 4;
  localparam int unsigned OUT_CH    = 2;
  localparam int unsigned DATA_W    = 16;
  localparam int unsigned CH_IDX_W  = 2;

  // configuration word layout: word 0 input enables, word 1 output enables
  localparam int unsigned CFG_EN_IN_POS   = 8;
  localparam int unsigned CFG_EN_OUT_POS  = 8;
  localparam logic [15:0] CFG0_UNUSED_MASK = 16'hf004;
  localparam logic [15:0] CFG1_UNUSED_MASK = 16'hfc04;

  // over-range limit on raw codes (full scale 10 V maps to this code)
  localparam logic [15:0] IN_LIMIT_DEF  = 16'h7fff;
  localparam logic [15:0] OUT_LIMIT_DEF = 16'h7fff;

  // self-check duration
  localparam int unsigned CHECK_NS     = 1000;
  localparam int unsigned CLK_NS       = 5;
  localparam int unsigned CHECK_CYCLES = (CHECK_NS + CLK_NS - 1) / CLK_NS;

  // reset values
  localparam logic [15:0] WORD_RST   = 16'h0000;
  localparam logic [3:0]  STAT_RST   = 4'h0;

  // one sample from the converter
  typedef struct packed {
    logic [CH_IDX_W-1:0] ch;
    logic [DATA_W-1:0]   value;
    logic                over;
  } sample_type;

  // one output word arriving from the bus
  typedef struct packed {
    logic                ch;
    logic [DATA_W-1:0]   value;
  } out_word_type;

endpackage

// ---- hdl/skid_buffer.sv ----
`timescale 1ns/1ps
`default_nettype none

// two-entry buffer; upstream ready depends only on fill level
module skid_buffer #(
  parameter int unsigned WIDTH = 8
) (
  // clock and reset
  input  wire logic             mclk_in,
  input  wire logic             rst_n_in,
  // fill side
  input  wire logic             s_valid_in,
  output logic                  s_ready_out,
  input  wire logic [WIDTH-1:0] s_data_in,
  // drain side
  output logic                  m_valid_out,
  input  wire logic             m_ready_in,
  output logic [WIDTH-1:0]      m_data_out
);

  logic [WIDTH-1:0] mem_r [2];
  logic [WIDTH-1:0] mem_nxt [2];
  logic [1:0]       cnt_r;
  logic [1:0]       cnt_nxt;
  logic             rd_r;
  logic             rd_nxt;
  logic             wr_r;
  logic             wr_nxt;
  logic             push;
  logic             pop;

  assign s_ready_out = (cnt_r != 2'd2);
  assign m_valid_out = (cnt_r != 2'd0);
  assign m_data_out  = mem_r[rd_r];
  assign push        = s_valid_in && s_ready_out;
  assign pop         = m_valid_out && m_ready_in;

  // pointer and count update
  always_comb begin
    mem_nxt = mem_r;
    wr_nxt  = wr_r;
    rd_nxt  = rd_r;
    cnt_nxt = cnt_r;
    if (push) begin
      mem_nxt[wr_r] = s_data_in;
      wr_nxt        = ~wr_r;
    end
    if (pop) begin
      rd_nxt = ~rd_r;
    end
    case ({push, pop})
      2'b10:   cnt_nxt = cnt_r + 2'd1;
      2'b01:   cnt_nxt = cnt_r - 2'd1;
      default: cnt_nxt = cnt_r;
    endcase
  end

  always_ff @(posedge mclk_in) begin
    mem_r <= mem_nxt;
    if (!rst_n_in) begin
      cnt_r <= 2'd0;
      rd_r  <= 1'b0;
      wr_r  <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      rd_r  <= rd_nxt;
      wr_r  <= wr_nxt;
    end
  end

endmodule // skid_buffer

`default_nettype wire

// ---- hdl/analog_io_sequencer.sv ----
`timescale 1ns/1ps
`default_nettype none

module analog_io_sequencer #(
  parameter int unsigned CHECK_LEN = aio_pkg::CHECK_CYCLES
) (
  // clock and reset
  input  wire logic                        mclk_in,
  input  wire logic                        rst_n_in,
  // self-check result
  input  wire logic                        check_fail_in,
  // configuration from the controller
  input  wire logic                        cfg_valid_in,
  input  wire logic [15:0]                 cfg_word0_in,
  input  wire logic [15:0]                 cfg_word1_in,
  // shared converter and multiplexer
  output logic [aio_pkg::CH_IDX_W-1:0]     mux_sel_out,
  output logic                             adc_start_out,
  input  wire logic                        adc_done_in,
  input  wire logic [aio_pkg::DATA_W-1:0]  adc_data_in,
  // input samples toward the controller
  output logic                             smp_valid_out,
  input  wire logic                        smp_ready_in,
  output aio_pkg::sample_type              smp_out,
  input  wire logic                        smp_xfer_ok_in,
  // output words from the controller
  input  wire logic                        out_valid_in,
  input  wire aio_pkg::out_word_type       out_word_in,
  input  wire logic                        out_xfer_ok_in,
  output logic [aio_pkg::DATA_W-1:0]       dac0_out,
  output logic [aio_pkg::DATA_W-1:0]       dac1_out,
  // status
  output logic                             status_led_out,
  output logic                             cfg_err_out,
  output logic [aio_pkg::IN_CH-1:0]        in_over_out,
  output logic [aio_pkg::OUT_CH-1:0]       out_over_out
);

  typedef enum logic [1:0] {
    ST_CHECK,
    ST_WAIT_CFG,
    ST_RUN,
    ST_FAULT
  } state_type;

  state_type                        st_r,      st_nxt;
  logic [15:0]                      cnt_r,     cnt_nxt;
  logic                             led_r,     led_nxt;
  logic                             err_r,     err_nxt;
  logic [aio_pkg::IN_CH-1:0]        in_en_r,   in_en_nxt;
  logic [aio_pkg::OUT_CH-1:0]       out_en_r,  out_en_nxt;
  logic [aio_pkg::CH_IDX_W-1:0]     sel_r,     sel_nxt;
  logic                             busy_r,    busy_nxt;
  logic                             start_r,   start_nxt;
  logic [aio_pkg::IN_CH-1:0]        iov_r,     iov_nxt;
  logic [aio_pkg::OUT_CH-1:0]       oov_r,     oov_nxt;
  logic [aio_pkg::DATA_W-1:0]       dac_r [2];
  logic [aio_pkg::DATA_W-1:0]       dac_nxt [2];
  logic                             buf_ready;
  logic                             buf_valid;
  aio_pkg::sample_type              buf_data;
  aio_pkg::sample_type              smp_new;
  logic                             smp_push;
  logic                             smp_take;
  logic                             cfg_bad;
  logic                             smp_v_r;
  aio_pkg::sample_type              smp_d_r;

  // bits 15:12 and 2 of word 0, or 15:10 and 2 of word 1, set to one make the setup invalid
  assign cfg_bad = |(cfg_word0_in & aio_pkg::CFG0_UNUSED_MASK)
                || |(cfg_word1_in & aio_pkg::CFG1_UNUSED_MASK);

  // one carrier word, over-range judged on every sample taken
  assign smp_new  = '{ch:    sel_r,
                      value: adc_data_in,
                      over:  adc_data_in > aio_pkg::IN_LIMIT_DEF};
  assign smp_push = busy_r && adc_done_in;
  // a sample retires only on a transfer both sides call clean; a bad one is offered again
  assign smp_take = smp_ready_in && smp_xfer_ok_in;

  // buffer decouples a slow controller from the converter pace
  skid_buffer #(.WIDTH($bits(aio_pkg::sample_type))) u_buf (
    .mclk_in     (mclk_in),
    .rst_n_in    (rst_n_in),
    .s_valid_in  (smp_push),
    .s_ready_out (buf_ready),
    .s_data_in   (smp_new),
    .m_valid_out (buf_valid),
    .m_ready_in  (!smp_v_r || smp_take),
    .m_data_out  (buf_data)
  );

  // output register stage keeps the sample port flop-driven
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      smp_v_r <= 1'b0;
      smp_d_r <= '0;
    end else if (!smp_v_r || smp_take) begin
      smp_v_r <= buf_valid;
      smp_d_r <= buf_data;
    end
  end

  // sequencer, configuration and status next state
  always_comb begin
    st_nxt     = st_r;
    cnt_nxt    = cnt_r;
    led_nxt    = led_r;
    err_nxt    = err_r;
    in_en_nxt  = in_en_r;
    out_en_nxt = out_en_r;
    sel_nxt    = sel_r;
    busy_nxt   = busy_r;
    start_nxt  = 1'b0;
    iov_nxt    = iov_r;
    oov_nxt    = oov_r;
    dac_nxt    = dac_r;
    case (st_r)
      ST_CHECK: begin
        led_nxt = 1'b0;
        if (cnt_r == 16'(CHECK_LEN - 1)) begin
          if (check_fail_in) begin
            st_nxt = ST_FAULT;
          end else begin
            st_nxt  = ST_WAIT_CFG;
            led_nxt = 1'b1;
          end
        end else begin
          cnt_nxt = cnt_r + 16'h0001;
        end
      end
      ST_WAIT_CFG, ST_RUN: begin
        if (cfg_valid_in) begin
          if (cfg_bad) begin
            err_nxt    = 1'b1;
            in_en_nxt  = '0;
            out_en_nxt = '0;
            st_nxt     = ST_WAIT_CFG;
          end else begin
            err_nxt    = 1'b0;
            in_en_nxt  = cfg_word0_in[aio_pkg::CFG_EN_IN_POS +: aio_pkg::IN_CH];
            out_en_nxt = cfg_word1_in[aio_pkg::CFG_EN_OUT_POS +: aio_pkg::OUT_CH];
            st_nxt     = ST_RUN;
          end
        end
        // a conversion in flight completes even if the setup was just dropped,
        // otherwise busy would stick and the scan would never restart
        if (smp_push) begin
          busy_nxt       = 1'b0;
          iov_nxt[sel_r] = smp_new.over;
          sel_nxt        = sel_r + 2'd1;
        end
        if (st_r == ST_RUN) begin
          // round robin over enabled inputs; judged on the setup about to hold
          if (!busy_r && buf_ready && st_nxt == ST_RUN && in_en_nxt[sel_r]) begin
            busy_nxt  = 1'b1;
            start_nxt = 1'b1;
          end else if (!busy_r && !in_en_nxt[sel_r]) begin
            iov_nxt[sel_r] = 1'b0;
            sel_nxt        = sel_r + 2'd1;
          end
          // output words land only on a confirmed transfer
          if (out_valid_in && out_xfer_ok_in && out_en_r[out_word_in.ch]) begin
            dac_nxt[out_word_in.ch] = out_word_in.value;
            oov_nxt[out_word_in.ch] = out_word_in.value > aio_pkg::OUT_LIMIT_DEF;
          end
        end
      end
      ST_FAULT: begin
        led_nxt = 1'b0;
      end
      default: st_nxt = ST_CHECK;
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      st_r     <= ST_CHECK;
      cnt_r    <= aio_pkg::WORD_RST;
      led_r    <= 1'b0;
      err_r    <= 1'b0;
      in_en_r  <= aio_pkg::STAT_RST;
      out_en_r <= '0;
      sel_r    <= '0;
      busy_r   <= 1'b0;
      start_r  <= 1'b0;
      iov_r    <= aio_pkg::STAT_RST;
      oov_r    <= '0;
      dac_r[0] <= aio_pkg::WORD_RST;
      dac_r[1] <= aio_pkg::WORD_RST;
    end else begin
      st_r     <= st_nxt;
      cnt_r    <= cnt_nxt;
      led_r    <= led_nxt;
      err_r    <= err_nxt;
      in_en_r  <= in_en_nxt;
      out_en_r <= out_en_nxt;
      sel_r    <= sel_nxt;
      busy_r   <= busy_nxt;
      start_r  <= start_nxt;
      iov_r    <= iov_nxt;
      oov_r    <= oov_nxt;
      dac_r    <= dac_nxt;
    end
  end

  // port drive, all from flops
  assign mux_sel_out    = sel_r;
  assign adc_start_out  = start_r;
  assign smp_valid_out  = smp_v_r;
  assign smp_out        = smp_d_r;
  assign dac0_out       = dac_r[0];
  assign dac1_out       = dac_r[1];
  assign status_led_out = led_r;
  assign cfg_err_out    = err_r;
  assign in_over_out    = iov_r;
  assign out_over_out   = oov_r;

  // checks
  chk_led_dark_check: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    st_r == ST_CHECK |-> !status_led_out) else $error("led lit during check");
  chk_led_on_pass: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    st_r == ST_CHECK && st_nxt == ST_WAIT_CFG |=> status_led_out)
    else $error("led not lit after pass");
  chk_no_start_wait: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    st_r != ST_RUN |=> !adc_start_out) else $error("conversion before config");
  chk_cfg_error_flag: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    st_r != ST_CHECK && st_r != ST_FAULT && cfg_valid_in && cfg_bad |=> cfg_err_out)
    else $error("bad config not flagged");
  chk_start_enabled: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    adc_start_out |-> in_en_r[mux_sel_out]) else $error("disabled channel converted");
  chk_in_over_set: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    st_r == ST_RUN && smp_push |=> in_over_out[$past(sel_r)] == $past(smp_new.over))
    else $error("input over-range wrong");
  chk_dac_confirmed: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    $changed(dac0_out) || $changed(dac1_out) |-> $past(out_valid_in && out_xfer_ok_in))
    else $error("output updated unconfirmed");
  chk_out_over: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    st_r == ST_RUN && out_valid_in && out_xfer_ok_in && out_en_r[out_word_in.ch]
    |=> out_over_out[$past(out_word_in.ch)]
        == ($past(out_word_in.value) > aio_pkg::OUT_LIMIT_DEF))
    else $error("output over-range wrong");
  chk_mux_advance: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    st_r == ST_RUN && smp_push |=> mux_sel_out == $past(sel_r) + 2'd1)
    else $error("mux did not advance");
  chk_smp_held_bad: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    smp_valid_out && !smp_take |=> smp_valid_out && $stable(smp_out))
    else $error("sample dropped without clean transfer");

  cov_pass: cover property (@(posedge mclk_in) st_r == ST_CHECK ##1 st_r == ST_WAIT_CFG);
  cov_run: cover property (@(posedge mclk_in) st_r == ST_RUN && smp_push);
  cov_bad_cfg: cover property (@(posedge mclk_in) cfg_err_out);
  cov_stall: cover property (@(posedge mclk_in) smp_valid_out && !smp_ready_in && !buf_ready);

endmodule // analog_io_sequencer

`default_nettype wire

// ---- testbench/ctrl_model.sv ----
`timescale 1ns/1ps
`default_nettype none

// converter and controller sitting at the far side of the sequencer
module ctrl_model (
  // clock and reset
  input  wire logic             mclk_in,
  input  wire logic             rst_n_in,
  // converter side
  input  wire logic             adc_start_in,
  input  wire logic [1:0]       mux_sel_in,
  output logic                  adc_done_out,
  output logic [15:0]           adc_data_out,
  // sample side
  input  wire logic             stall_in,
  output logic                  smp_ready_out,
  // scenario controls
  input  wire logic             slow_in,
  input  wire logic [3:0][15:0] ch_val_in
);
  int         wait_r;
  logic [1:0] sel_r;

  // the controller takes samples whenever its scan is not held off
  assign smp_ready_out = !stall_in;

  // one conversion at a time; idle data toggles so a stale code never passes
  always @(posedge mclk_in) begin
    adc_done_out <= 1'b0;
    if (!rst_n_in) begin
      wait_r       <= 0;
      adc_data_out <= 16'h0000;
    end else if (adc_start_in) begin
      sel_r        <= mux_sel_in;
      wait_r       <= slow_in ? 6 : 2;
      adc_data_out <= ~adc_data_out;
    end else if (wait_r == 1) begin
      adc_done_out <= 1'b1;
      adc_data_out <= ch_val_in[sel_r];
      wait_r       <= 0;
    end else begin
      if (wait_r > 0) wait_r <= wait_r - 1;
      adc_data_out <= ~adc_data_out;
    end
  end
endmodule // ctrl_model

`default_nettype wire

// ---- testbench/analog_io_sequencer_test.sv ----
`timescale 1ns/1ps
`default_nettype none

module analog_io_sequencer_test;
  localparam int unsigned CHECK_LEN = 4;

  // rows: inputs beside the results they should give
  typedef struct packed {
    logic [15:0] w0;
    logic [15:0] w1;
    logic        err;
  } cfg_row_type;
  typedef struct packed {
    logic        ch;
    logic [15:0] val;
    logic        ok;
    logic [15:0] d0;
    logic [15:0] d1;
    logic [1:0]  ovr;
  } out_row_type;

  localparam cfg_row_type CFG_ROWS [4] = '{
    '{16'h0f04, 16'h0300, 1'b1}, '{16'h0f00, 16'h0700, 1'b1},
    '{16'h8f00, 16'h0300, 1'b1}, '{16'h0f00, 16'h0300, 1'b0}};
  localparam out_row_type OUT_ROWS [6] = '{
    '{1'b0, 16'h1234, 1'b1, 16'h1234, 16'h0000, 2'b00},
    '{1'b1, 16'h8000, 1'b1, 16'h1234, 16'h8000, 2'b10},
    '{1'b0, 16'h5555, 1'b0, 16'h1234, 16'h8000, 2'b10},
    '{1'b1, 16'h0100, 1'b1, 16'h1234, 16'h0100, 2'b00},
    '{1'b0, 16'hffff, 1'b1, 16'hffff, 16'h0100, 2'b01},
    '{1'b0, 16'h7fff, 1'b1, 16'h7fff, 16'h0100, 2'b00}};

  logic                  mclk_in = 1'b0;
  logic                  rst_n_in = 1'b0;
  logic                  check_fail_in = 1'b0;
  logic                  cfg_valid = 1'b0;
  logic [15:0]           cfg_w0 = 16'h0000;
  logic [15:0]           cfg_w1 = 16'h0000;
  logic                  out_valid = 1'b0;
  logic                  out_ok = 1'b0;
  aio_pkg::out_word_type out_word = '0;
  logic                  stall = 1'b0;
  logic                  slow = 1'b0;
  logic                  smp_ok = 1'b1;
  logic [3:0][15:0]      ch_val = {16'h0300, 16'h8000, 16'h7fff, 16'h0001};
  logic [1:0]            mux_sel;
  logic                  adc_start;
  logic                  adc_done;
  logic [15:0]           adc_data;
  logic                  smp_valid;
  logic                  smp_ready;
  aio_pkg::sample_type   smp;
  logic [15:0]           dac0;
  logic [15:0]           dac1;
  logic                  status_led;
  logic                  cfg_err;
  logic [3:0]            in_over;
  logic [1:0]            out_over;
  logic                  run_ok = 1'b0;
  logic                  vchk = 1'b1;
  logic                  have_prev = 1'b0;
  logic [1:0]            prev_ch = 2'b00;
  int                    n_fail = 0;
  int                    n_tests = 0;

  always #2.5 mclk_in = ~mclk_in;

  analog_io_sequencer #(.CHECK_LEN(CHECK_LEN)) i_analog_io_sequencer (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .check_fail_in(check_fail_in),
    .cfg_valid_in(cfg_valid), .cfg_word0_in(cfg_w0), .cfg_word1_in(cfg_w1),
    .mux_sel_out(mux_sel), .adc_start_out(adc_start), .adc_done_in(adc_done),
    .adc_data_in(adc_data), .smp_valid_out(smp_valid), .smp_ready_in(smp_ready),
    .smp_out(smp), .smp_xfer_ok_in(smp_ok),
    .out_valid_in(out_valid), .out_word_in(out_word), .out_xfer_ok_in(out_ok),
    .dac0_out(dac0), .dac1_out(dac1), .status_led_out(status_led),
    .cfg_err_out(cfg_err), .in_over_out(in_over), .out_over_out(out_over));

  ctrl_model i_ctrl_model (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .adc_start_in(adc_start),
    .mux_sel_in(mux_sel), .adc_done_out(adc_done), .adc_data_out(adc_data),
    .stall_in(stall), .smp_ready_out(smp_ready), .slow_in(slow), .ch_val_in(ch_val));

  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask

  // the guard follows one edge after the word: a start launched before it may still show
  task automatic send_cfg(input cfg_row_type r);
    tick(1);
    cfg_valid = 1'b1;
    cfg_w0 = r.w0;
    cfg_w1 = r.w1;
    tick(1);
    cfg_valid = 1'b0;
    run_ok = !r.err;
    tick(1);
    check(cfg_err, r.err, "config error");
    tick(2);
  endtask

  task automatic send_out(input out_row_type r);
    tick(1);
    out_valid = 1'b1;
    out_ok = r.ok;
    out_word = '{ch: r.ch, value: r.val};
    tick(1);
    out_valid = 1'b0;
    out_ok = 1'b0;
    tick(1);
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // every accepted sample is judged against the codes fed to the converter while vchk is set
  always @(posedge mclk_in) begin
    if (rst_n_in) check(adc_start & ~run_ok, 1'b0, "conversion while waiting");
    if (smp_valid && smp_ready && smp_ok && vchk) begin
      if (have_prev) check(smp.ch, 2'(prev_ch + 2'd1), "scan order");
      check(smp.value, ch_val[smp.ch], "sample value");
      check(smp.over, ch_val[smp.ch] > 16'h7fff, "sample over-range");
      check(in_over[smp.ch], smp.over, "input over-range flag");
      prev_ch = smp.ch;
      have_prev = 1'b1;
    end
  end

  initial begin
    #100000;
    n_fail++;
    $display("CHECK FAILED t=%0t watchdog expired", $time);
    stop_test();
  end

  initial begin
    tick(20);
    rst_n_in = 1'b1;
    check(status_led, 1'b0, "indicator during self-check");
    tick(CHECK_LEN + 4);
    check(status_led, 1'b1, "indicator after self-check");
    foreach (CFG_ROWS[i]) send_cfg(CFG_ROWS[i]);
    foreach (OUT_ROWS[i]) begin
      send_out(OUT_ROWS[i]);
      check(dac0, OUT_ROWS[i].d0, "dac0 code");
      check(dac1, OUT_ROWS[i].d1, "dac1 code");
      check(out_over, OUT_ROWS[i].ovr, "output over-range");
    end
    // stall long enough to fill the buffer, then run a slow converter
    stall = 1'b1;
    tick(60);
    check(smp_valid, 1'b1, "sample held while stalled");
    check(in_over, 4'h4, "input flags");
    stall = 1'b0;
    // bad transfers: the sample must stay on offer and none may go missing
    smp_ok = 1'b0;
    tick(20);
    check(smp_valid, 1'b1, "sample held on bad transfer");
    smp_ok = 1'b1;
    slow = 1'b1;
    tick(80);
    slow = 1'b0;
    // channel 2 back in range; in-flight samples still carry the old code
    vchk = 1'b0;
    ch_val[2] = 16'h0200;
    tick(40);
    check(in_over, 4'h0, "input flag clears");
    have_prev = 1'b0;
    vchk = 1'b1;
    tick(40);
    // output 1 and inputs 1 and 3 dropped: words go unheard, the scan skips
    vchk = 1'b0;
    send_cfg('{16'h0500, 16'h0100, 1'b0});
    send_out('{1'b1, 16'h4321, 1'b1, 16'h0000, 16'h0000, 2'b00});
    check(dac1, 16'h0100, "disabled output unchanged");
    // a bad word clears all enables: conversions and output 0 stop
    send_cfg('{16'h0f00, 16'h0b00, 1'b1});
    tick(30);
    send_out('{1'b0, 16'h0042, 1'b1, 16'h0000, 16'h0000, 2'b00});
    check(dac0, 16'h7fff, "output held after bad config");
    // a failing self-check leaves the indicator dark
    check_fail_in = 1'b1;
    rst_n_in = 1'b0;
    tick(20);
    rst_n_in = 1'b1;
    check(status_led, 1'b0, "indicator during second check");
    tick(CHECK_LEN + 10);
    check(status_led, 1'b0, "indicator after failed check");
    stop_test();
  end
endmodule // analog_io_sequencer_test

`default_nettype wire
